// File: rtl/fsm_addr_map.sv
// Address decoder: sector and block indices, range and protection check
`timescale 1ns/100ps
`default_nettype none
module fsm_addr_map
(
    // Address and configuration
    input wire logic [18:0] i_addr,
    input wire logic [2:0] i_density,
    input wire logic [3:0] i_protect,
    // Decoded results
    output logic [6:0] o_sector,
    output logic [3:0] o_block32,
    output logic [2:0] o_block64,
    output logic o_in_range,
    output logic o_protected
);
    logic [18:0] top_addr;
    logic [3:0] blk64_count;
    logic [3:0] prot_blocks;

    // Simple protection model: protect_bit value counts top 64K-granule units
    always_comb
    begin
        o_sector = i_addr[18:fsm_pkg::SECTOR_LSB]; // see R11 R3
        o_block32 = i_addr[18:fsm_pkg::BLK32_LSB]; // see R11 R1
        o_block64 = i_addr[18:fsm_pkg::BLK64_LSB]; // see R11 R2
        unique case (i_density)
            fsm_pkg::DENS_256K: top_addr = 19'h07FFF;
            fsm_pkg::DENS_512K: top_addr = 19'h0FFFF;
            fsm_pkg::DENS_1M: top_addr = 19'h1FFFF;
            fsm_pkg::DENS_2M: top_addr = 19'h3FFFF;
            default: top_addr = fsm_pkg::ADDR_TOP;
        endcase
        o_in_range = (i_addr <= top_addr);
        blk64_count = {1'b0, top_addr[18:16]} + 4'h1;
        prot_blocks = (i_protect > blk64_count) ? blk64_count : i_protect;
        // Region counted down from the top; small parts protect whole array
        if (i_protect == 4'h0)
            o_protected = 1'b0;
        else if (top_addr[18:16] == 3'h0)
            o_protected = 1'b1;
        else
            o_protected = ({1'b0, o_block64} >= (blk64_count - prot_blocks)); // see R5
    end
endmodule
`default_nettype wire

// File: rtl/fsm_pkg.sv
// Package with status register layout, address map and timing constants
package fsm_pkg;
    // Status register field positions
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_WEL_BIT = 1;
    localparam int unsigned STAT_PROT_LSB = 2;
    localparam int unsigned STAT_PROT_MSB = 5;
    localparam int unsigned STAT_QUAD_BIT = 6;
    localparam int unsigned STAT_GUARD_BIT = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;
    // Bits that a status write command may change
    localparam logic [7:0] STAT_WRITABLE_MASK = 8'hFC;
    // Address map
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned SECTOR_LSB = 12;
    localparam int unsigned BLK32_LSB = 15;
    localparam int unsigned BLK64_LSB = 16;
    localparam logic [18:0] ADDR_TOP = 19'h7FFFF;
    // Density selector codes
    localparam logic [2:0] DENS_256K = 3'h0;
    localparam logic [2:0] DENS_512K = 3'h1;
    localparam logic [2:0] DENS_1M = 3'h2;
    localparam logic [2:0] DENS_2M = 3'h3;
    localparam logic [2:0] DENS_4M = 3'h4;
    // Internal register write cycle time
    localparam int unsigned REG_WRITE_NS = 100;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned REG_WRITE_CYC = (REG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {FSM_IDLE, FSM_REG_WRITE, FSM_ARRAY_OP} fsm_state_e;
endpackage

// File: rtl/fsm_status.sv
// Status register bank with write guard, latch and busy sequencing
//
// Behaviour
// R1 - Small densities split the array into 4 KB sectors, eight to a 32 KB block.
// R2 - Larger densities use 4 KB sectors in 32 KB or 64 KB blocks.
// R3 - Addresses run linearly from zero, 4 KB per sector, up to 07FFFFh.
// R4 - The 8-bit status register holds guard, quad, four protect bits, latch, busy; all reset to 0.
// R5 - The status register contents decide which regions reject program and erase.
// R6 - Only two register sets exist, status and function; only status is here.
// R7 - Busy is high during any program, erase or register write cycle.
// R8 - The latch sets on write enable, clears on write disable and after any write.
// R9 - Guard high with write protect low freezes the upper bits and ignores status writes.
// R10 - Quad enable turns write protect and hold into data lanes 2 and 3.
// R11 - Sector index is address bits 12 up; block indices bits 15 or 16 up.
`timescale 1ns/100ps
`default_nettype none
module fsm_status
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration
    input wire logic [2:0] i_density,
    // Pins
    input wire logic i_wp_n_pin,
    input wire logic i_hold_n_pin,
    // Decoded commands from the serial front end, one-cycle pulses
    input wire logic i_write_enable_command,
    input wire logic i_write_disable_command,
    input wire logic i_status_write_command,
    input wire logic [7:0] i_status_wdata,
    input wire logic i_status_read_command,
    input wire logic i_array_op_start,
    input wire logic [18:0] i_array_addr,
    input wire logic i_array_op_done,
    // Status and decoded results
    output logic [7:0] o_status_rdata,
    output logic [7:0] o_status,
    output logic o_array_op_go,
    output logic o_array_op_refused,
    output logic o_quad_lane_enable,
    output logic o_hold_active,
    output logic o_io2_in,
    output logic o_io3_in,
    output logic [6:0] o_sector,
    output logic [3:0] o_block32,
    output logic [2:0] o_block64
);
    logic wp_meta;
    logic wp_sync;
    logic hold_meta;
    logic hold_sync;
    logic status_write_guard;
    logic quad_lane_enable;
    logic [3:0] protect_bits;
    logic write_enable_latch;
    logic busy_flag;
    logic [7:0] pending_wdata;
    logic [7:0] cyc_cnt;
    fsm_pkg::fsm_state_e state;
    logic guard_locked;
    logic in_range;
    logic region_protected;
    logic status_accept;
    logic array_accept;
    logic write_done;

    // Pins are asynchronous; two stages before use
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
            hold_meta <= 1'b1;
            hold_sync <= 1'b1;
        end
        else
        begin
            wp_meta <= i_wp_n_pin;
            wp_sync <= wp_meta;
            hold_meta <= i_hold_n_pin;
            hold_sync <= hold_meta;
        end
    end

    fsm_addr_map u_map
    (
        .i_addr(i_array_addr),
        .i_density(i_density),
        .i_protect(protect_bits),
        .o_sector(o_sector),
        .o_block32(o_block32),
        .o_block64(o_block64),
        .o_in_range(in_range),
        .o_protected(region_protected)
    );

    // Write protect pin is meaningless while it carries data
    assign guard_locked = status_write_guard && !wp_sync && !quad_lane_enable; // see R9 R10
    assign status_accept = i_status_write_command && write_enable_latch && !busy_flag
        && !guard_locked; // see R9 R8
    assign array_accept = i_array_op_start && write_enable_latch && !busy_flag
        && in_range && !region_protected; // see R5 R8
    assign write_done = ((state == fsm_pkg::FSM_REG_WRITE) && (cyc_cnt == 8'h00))
        || ((state == fsm_pkg::FSM_ARRAY_OP) && i_array_op_done);
    assign o_array_op_go = array_accept;
    assign o_array_op_refused = i_array_op_start && !array_accept;

    // Write cycle sequencing; register writes take a fixed internal time
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= fsm_pkg::FSM_IDLE;
            cyc_cnt <= 8'h00;
            pending_wdata <= 8'h00;
        end
        else
        begin
            unique case (state)
                fsm_pkg::FSM_IDLE:
                    if (status_accept)
                    begin
                        state <= fsm_pkg::FSM_REG_WRITE;
                        cyc_cnt <= 8'(fsm_pkg::REG_WRITE_CYC - 1);
                        pending_wdata <= i_status_wdata;
                    end
                    else if (array_accept)
                        state <= fsm_pkg::FSM_ARRAY_OP;
                fsm_pkg::FSM_REG_WRITE:
                    if (cyc_cnt == 8'h00)
                        state <= fsm_pkg::FSM_IDLE;
                    else
                        cyc_cnt <= cyc_cnt - 8'h01;
                fsm_pkg::FSM_ARRAY_OP:
                    if (i_array_op_done)
                        state <= fsm_pkg::FSM_IDLE;
            endcase
        end
    end

    // Busy follows the sequencer
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            busy_flag <= 1'b0;
        else if (status_accept || array_accept)
            busy_flag <= 1'b1; // see R7
        else if (write_done)
            busy_flag <= 1'b0; // see R7
    end

    // Latch: disable and completion clear; enable wins over both
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            write_enable_latch <= 1'b0;
        else if (i_write_enable_command)
            write_enable_latch <= 1'b1; // see R8
        else if (i_write_disable_command || write_done)
            write_enable_latch <= 1'b0; // see R8
    end

    // Upper bits commit at the end of the register write cycle
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            status_write_guard <= fsm_pkg::STAT_RESET[fsm_pkg::STAT_GUARD_BIT]; // see R4
            quad_lane_enable <= fsm_pkg::STAT_RESET[fsm_pkg::STAT_QUAD_BIT];
            protect_bits <= fsm_pkg::STAT_RESET[fsm_pkg::STAT_PROT_MSB:fsm_pkg::STAT_PROT_LSB];
        end
        else if ((state == fsm_pkg::FSM_REG_WRITE) && (cyc_cnt == 8'h00))
        begin
            status_write_guard <= pending_wdata[fsm_pkg::STAT_GUARD_BIT];
            quad_lane_enable <= pending_wdata[fsm_pkg::STAT_QUAD_BIT];
            protect_bits <= pending_wdata[fsm_pkg::STAT_PROT_MSB:fsm_pkg::STAT_PROT_LSB];
        end
    end

    // Assembled register; only the status set is modelled here
    always_comb
    begin
        o_status = {status_write_guard, quad_lane_enable, protect_bits,
            write_enable_latch, busy_flag}; // see R4 R6
    end

    // Read data captured on each read command
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_status_rdata <= fsm_pkg::STAT_RESET;
        else if (i_status_read_command)
            o_status_rdata <= o_status;
    end

    // Pin function selection
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_quad_lane_enable <= 1'b0;
            o_hold_active <= 1'b0;
            o_io2_in <= 1'b0;
            o_io3_in <= 1'b0;
        end
        else
        begin
            o_quad_lane_enable <= quad_lane_enable; // see R10
            o_hold_active <= !quad_lane_enable && !hold_sync; // see R10
            o_io2_in <= quad_lane_enable && wp_sync;
            o_io3_in <= quad_lane_enable && hold_sync;
        end
    end
endmodule
`default_nettype wire

// File: tb/fsm_host_model.sv
// Far side stand-in: answers each array go with a done pulse
`timescale 1ns/100ps
`default_nettype none
module fsm_host_model
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_delay,
    output logic o_done
);
    int cnt = 0;
    initial o_done = 1'b0;
    always @(posedge i_clk)
    begin
        o_done <= (cnt == 1);
        if (i_go)
            cnt <= i_delay;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// File: tb/fsm_status_props.sv
// Checker for the status register bank
`timescale 1ns/100ps
`default_nettype none
module fsm_status_props
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Commands
    input wire logic i_write_enable_command,
    input wire logic i_write_disable_command,
    input wire logic i_status_write_command,
    input wire logic i_status_read_command,
    input wire logic i_array_op_start,
    input wire logic [18:0] i_array_addr,
    // Results
    input wire logic [7:0] o_status_rdata,
    input wire logic [7:0] o_status,
    input wire logic o_array_op_go,
    input wire logic o_array_op_refused,
    input wire logic [6:0] o_sector,
    input wire logic [3:0] o_block32,
    input wire logic [2:0] o_block64
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Guard clear keeps the synced pin out of the condition
    sequence s_wr_taken;
        i_status_write_command && o_status[1] && !o_status[0] && !o_status[7];
    endsequence
    sequence s_reg_cycle;
        o_status[0] [*8] ##1 o_status[0] [*8] ##1 o_status[0] [*4]
            ##1 (!o_status[0] && !o_status[1]);
    endsequence
    reset_zero_a: assert property ($fell(i_rst) |-> o_status == 8'h00)
        else $error("status not cleared by reset");
    wel_set_a: assert property (i_write_enable_command |=> o_status[1])
        else $error("latch not set");
    wel_clr_a: assert property (i_write_disable_command && !i_write_enable_command
        && !o_status[0] |=> !o_status[1]) else $error("latch not cleared");
    reg_busy_a: assert property (s_wr_taken |=> s_reg_cycle)
        else $error("register write cycle wrong");
    addr_split_a: assert property ({o_sector, o_block32, o_block64} ==
        {i_array_addr[18:12], i_array_addr[18:15], i_array_addr[18:16]}) else $error("decode");
    op_excl_a: assert property ({1'b0, o_array_op_go} + {1'b0, o_array_op_refused}
        == {1'b0, i_array_op_start}) else $error("go and refused disagree with start");
    op_wel_a: assert property (i_array_op_start && !o_status[1] |-> o_array_op_refused)
        else $error("array start taken without latch");
    rdata_snap_a: assert property (i_status_read_command |=>
        o_status_rdata == $past(o_status)) else $error("read data wrong");
    upper_hold_a: assert property (!$fell(o_status[0]) |-> $stable(o_status[7:2]))
        else $error("upper bits moved outside completion");
endmodule
bind fsm_status fsm_status_props u_props (.*);
`default_nettype wire

// File: tb/test_flash_sector_map_status_reg.sv
// Self-checking bench for the status register bank
`timescale 1ns/100ps
`default_nettype none
module test_flash_sector_map_status_reg;
    logic i_clk = 0, i_rst = 1, wp = 1, hold = 1, we = 0, wd = 0, sw = 0, rd = 0, st = 0;
    logic done, go, refd, qe, hact, io2, io3;
    logic [2:0] dens = 3'h4;
    logic [7:0] wdat = 8'h00, rdata, stat, v;
    logic [18:0] addr = 19'h00000;
    logic [19:0] sz;
    logic [6:0] sec;
    logic [3:0] b32;
    logic [2:0] b64;
    logic [31:0] seed = 32'h37;
    int failures = 0, num_checks = 0, cyc = 0;
    always #2.5 i_clk = ~i_clk;
    fsm_status uut (.i_clk(i_clk), .i_rst(i_rst), .i_density(dens), .i_wp_n_pin(wp),
        .i_hold_n_pin(hold), .i_write_enable_command(we), .i_write_disable_command(wd),
        .i_status_write_command(sw), .i_status_wdata(wdat), .i_status_read_command(rd),
        .i_array_op_start(st), .i_array_addr(addr), .i_array_op_done(done),
        .o_status_rdata(rdata), .o_status(stat), .o_array_op_go(go),
        .o_array_op_refused(refd), .o_quad_lane_enable(qe), .o_hold_active(hact),
        .o_io2_in(io2), .o_io3_in(io3), .o_sector(sec), .o_block32(b32), .o_block64(b64));
    fsm_host_model host (.i_clk(i_clk), .i_go(go), .i_delay(8'h05), .o_done(done));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Linear map: 4 KB sectors, 32 KB and 64 KB blocks counted from zero
    function automatic logic [13:0] exp_split(logic [18:0] a);
        return {7'(a / 19'h01000), 4'(a / 19'h08000), 3'(a / 19'h10000)};
    endfunction
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (exp !== got)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge i_clk);
        s = 1'b1;
        @(negedge i_clk);
        s = 1'b0;
    endtask
    task automatic idle();
        repeat (40)
            if (stat[0] === 1'b1)
                @(negedge i_clk);
    endtask
    task automatic status_write_command(logic [7:0] val);
        pulse(we);
        wdat = val;
        pulse(sw);
        idle();
    endtask
    task automatic arr(logic [18:0] a, logic exp);
        pulse(we);
        addr = a;
        st = 1'b1;
        #1 chk("go", exp, go);
        chk("refused", !exp, refd);
        @(negedge i_clk);
        st = 1'b0;
        idle();
        chk("latch", !exp, stat[1]);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            failures++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(negedge i_clk);
        i_rst = 0;
        chk("reset", 8'h00, stat);
        for (int d = 0; d < 5; d++)
        begin
            dens = d[2:0];
            sz = 20'h08000 << d;
            for (int k = 0; k < 10; k++)
            begin
                addr = 19'(rnd());
                #1 chk("decode", exp_split(addr), {sec, b32, b64});
                @(negedge i_clk);
            end
            if (d < 4)
                arr(sz[18:0], 1'b0);
            arr(sz[18:0] - 19'h1, 1'b1);
        end
        pulse(we);
        pulse(wd);
        wdat = 8'hFF;
        pulse(sw);
        chk("no latch write", 8'h00, stat);
        repeat (8)
        begin
            v = 8'(rnd()) & 8'h3C;
            status_write_command(v);
            chk("status", v, stat);
            pulse(rd);
            chk("read", v, rdata);
        end
        status_write_command(8'h04);
        arr(19'h70000, 1'b0);
        arr(19'h6FFFF, 1'b1);
        status_write_command(8'h40);
        repeat (3) @(negedge i_clk);
        chk("quad pins high", 4'hE, {qe, io2, io3, hact});
        wp = 0;
        hold = 0;
        repeat (3) @(negedge i_clk);
        chk("quad pins low", 4'h8, {qe, io2, io3, hact});
        status_write_command(8'h80);
        status_write_command(8'h00);
        // Ignored write leaves the latch set by its enable
        chk("guard lock", 8'h82, stat);
        chk("hold", 1'b1, hact);
        wp = 1;
        repeat (3) @(negedge i_clk);
        status_write_command(8'h00);
        chk("guard open", 8'h00, stat);
        end_of_test();
    end
endmodule
`default_nettype wire
